/* design/cfs_compare_ctrl.sv */
// second control stage of one output compare channel
// assumes the compare core, timers and trigger sources share mclk_i
`timescale 1ns/1ps
`default_nettype none
`include "cfs_params.svh"

// How it works
// [RULE1] hold select 1: fault ends when source gone and status cleared
// [RULE2] hold select 0: fault ends when source gone at next period start
// [RULE3] during fault the pin is driven to the fault drive level
// [RULE4] pin force bit makes a fault force the pin to output
// [RULE5] invert bit presents the inverse of the compare output
// [RULE6] two-bit delay field shifts the falling edge by quarter cycles
// [RULE7] with invert set the delay applies to the rising edge
// [RULE8] delay field ignored in single-shot drive-high mode
// [RULE9] cascade bit joins two channels into one 32-bit compare
// [RULE10] trigger select 1 starts on trigger, 0 synchronises timebase
// [RULE11] run status set on trigger; timer held clear while it is clear
// [RULE12] tristate bit releases the pin, otherwise compare drives it
// [RULE13] codes 01011..01111 select timers one to five
// [RULE14] code 00000 runs unsynchronised
// [RULE15] codes 00001..00101 select compare channels, 11111 selects self
// [RULE16] software uses trigger-only sources never for synchronisation
// [RULE17] software never selects this channel as its own trigger
// [RULE18] auto-clear drops run status on secondary value equal count
// [RULE19] in pwm modes the delay field takes effect at period start
// [RULE20] fault status recorded only in center-aligned pwm mode
// [RULE21] reserved codes act as no source; bit 11 reads zero
module cfs_compare_ctrl
  import cfs_pkg::*;
#(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned CNT_W  = 16
)
(
  input  wire logic              mclk_i,        // system clock
  input  wire logic              arst_n_i,      // async reset, active low
  input  wire logic              clk_en_i,      // freezes all state when low
  input  wire logic [ADDR_W-1:0] reg_addr_i,    // register index
  input  wire logic [15:0]       reg_wdata_i,   // write data
  input  wire logic              reg_wr_i,      // write strobe
  input  wire logic              reg_rd_i,      // read strobe
  output logic      [15:0]       reg_rdata_o,   // read data, cycle after
  input  wire logic [2:0]        compare_mode_select_i,     // core mode
  input  wire logic              trigger_status_auto_clear_i, // auto-clear
  input  wire logic [CNT_W-1:0]  secondary_compare_value_i, // secondary
  input  wire logic [CNT_W-1:0]  compare_timer_count_i,     // timer count
  input  wire logic              cmp_level_i,   // raw compare output
  input  wire logic              period_start_i, // pwm period start pulse
  input  wire logic              fault_src_i,   // fault pin, async
  input  wire logic [31:0]       src_event_i,   // source pulses by code
  output logic                   compare_output_pin_o,  // pin level
  output logic                   compare_output_pin_oe_o, // pin enable
  output logic [1:0]             edge_delay_o,  // quarter-cycle delay
  output logic                   delay_on_rise_o, // delay the rising edge
  output logic                   cascade_enable_o, // 32-bit pairing
  output logic                   timer_hold_o,  // hold timer at zero
  output logic                   timer_sync_o,  // timebase sync pulse
  output logic                   fault_a_status_o, // fault recorded
  output logic                   trigger_run_status_o // triggered, running
);

  logic [15:0]    ctrl_q;
  logic           run_q;
  logic           flt_stat_q;
  logic [1:0]     dly_act_q;
  logic           flt_s1_q;
  logic           flt_s2_q;
  cfs_flt_state_t flt_state_q;
  cfs_src_kind_t  src_kind;
  logic           pwm_mode;
  logic           ctr_mode;
  logic           src_hit;
  logic           wr_ctrl;
  logic           wr_stat;
  logic           auto_clr;
  logic           fault_now;
  logic [4:0]     src_code;

  // source code taken from the control register, register strobes decoded from the plain port
  assign src_code = ctrl_q[`CFS_BIT_SRC_HI:0];
  assign wr_ctrl  = reg_wr_i && (reg_addr_i == ADDR_W'(`CFS_OFS_CTRL2));
  assign wr_stat  = reg_wr_i && (reg_addr_i == ADDR_W'(`CFS_OFS_STATUS));

  // pwm modes gate the fault path and the delay double buffer
  assign pwm_mode = (compare_mode_select_i == `CFS_MODE_PWM_EDGE)
                 || (compare_mode_select_i == `CFS_MODE_PWM_CTR);
  assign ctr_mode = (compare_mode_select_i == `CFS_MODE_PWM_CTR);

  // classify the source code; trigger-only and reserved codes never sync
  always_comb
  begin
    if ((src_code >= `CFS_SRC_CMP_FIRST && src_code <= `CFS_SRC_CMP_LAST)
        || (src_code >= `CFS_SRC_TMR_FIRST && src_code <= `CFS_SRC_TMR_LAST)
        || src_code == `CFS_SRC_SELF)                      // [RULE13] [RULE15]
      src_kind = CFS_SRC_KIND_SYNC;
    else if ((src_code >= `CFS_SRC_TRG_FIRST && src_code <= `CFS_SRC_TRG_LAST)
             || src_code == `CFS_SRC_CAP5)                 // [RULE16]
      src_kind = CFS_SRC_KIND_TRIG;
    else
      src_kind = CFS_SRC_KIND_NONE;                        // [RULE14] [RULE21]
  end

  // self code relies on software never using it as a trigger
  assign src_hit = (src_kind != CFS_SRC_KIND_NONE) && src_event_i[src_code]; // [RULE17]

  // auto-clear acts on every cycle the values match, not only on an edge
  assign auto_clr = trigger_status_auto_clear_i
                 && (secondary_compare_value_i == compare_timer_count_i); // [RULE18]

  // fault pin passes two flops before anything looks at it
  // costs two cycles of fault latency but keeps metastability out
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      flt_s1_q <= fault_src_i;
      flt_s2_q <= flt_s1_q;
    end
  end

  // a fault only counts while a pwm mode is active
  assign fault_now = flt_s2_q && pwm_mode;

  // control register; run status bit kept apart, bit 11 never stored
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ctrl_q <= `CFS_CTRL2_RESET;
    else if (clk_en_i && wr_ctrl)
      ctrl_q <= reg_wdata_i & `CFS_CTRL2_WMASK;            // [RULE21]
  end

  // run status: hardware set beats any clear in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (ctrl_q[`CFS_BIT_TRIG_SEL] && src_hit)
        run_q <= 1'b1;                                     // [RULE11]
      // software may write bit 6 either way; auto-clear comes last
      else if (wr_ctrl)
        run_q <= reg_wdata_i[`CFS_BIT_RUN_STAT];
      else if (auto_clr)
        run_q <= 1'b0;                                     // [RULE18]
    end
  end

  // fault status recorded only in center-aligned mode; set wins over clear
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flt_stat_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (flt_s2_q && ctr_mode)
        flt_stat_q <= 1'b1;                                // [RULE20]
      // write one to clear; a fault still present sets it again
      else if (wr_stat && reg_wdata_i[`CFS_BIT_FLT_STAT])
        flt_stat_q <= 1'b0;
    end
  end

  // fault state: exit policy depends on the hold select
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flt_state_q <= CFS_FLT_IDLE;
    else if (clk_en_i)
    begin
      unique case (flt_state_q)
        CFS_FLT_IDLE:
          if (fault_now)
            flt_state_q <= CFS_FLT_ACTIVE;
        CFS_FLT_ACTIVE:
          if (!flt_s2_q)
          begin
            // hold select 1 also waits for software to clear the status
            if (ctrl_q[`CFS_BIT_FLT_HOLD])
            begin
              if (!flt_stat_q)
                flt_state_q <= CFS_FLT_IDLE;               // [RULE1]
            end
            // hold select 0 leaves only on a period boundary
            else if (period_start_i)
              flt_state_q <= CFS_FLT_IDLE;                 // [RULE2]
          end
      endcase
    end
  end

  // delay field double-buffered in pwm modes so a period stays clean
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dly_act_q <= 2'b00;
    // outside pwm the active copy tracks the register every cycle
    else if (clk_en_i && (!pwm_mode || period_start_i))
      dly_act_q <= ctrl_q[`CFS_BIT_DLY_HI:`CFS_BIT_DLY_LO]; // [RULE19]
  end

  // pin level, direction and delay hints, all registered
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_output_pin_o    <= 1'b0;
      compare_output_pin_oe_o <= 1'b1;
      edge_delay_o            <= 2'b00;
      delay_on_rise_o         <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // fault drive level goes to the pin as is, the invert bit is not applied
      if (flt_state_q == CFS_FLT_ACTIVE)
        compare_output_pin_o <= ctrl_q[`CFS_BIT_FLT_LEVEL]; // [RULE3]
      else
        compare_output_pin_o <= cmp_level_i ^ ctrl_q[`CFS_BIT_INVERT]; // [RULE5]
      // force overrides the tristate request only while a fault lasts
      if (flt_state_q == CFS_FLT_ACTIVE && ctrl_q[`CFS_BIT_FLT_FORCE])
        compare_output_pin_oe_o <= 1'b1;                   // [RULE4]
      else
        compare_output_pin_oe_o <= !ctrl_q[`CFS_BIT_TRISTATE]; // [RULE12]
      // the sub-cycle shift itself is done by the pad delay line
      if (compare_mode_select_i == `CFS_MODE_SS_HIGH)
        edge_delay_o <= 2'b00;                             // [RULE8]
      else
        edge_delay_o <= dly_act_q;                         // [RULE6]
      delay_on_rise_o <= ctrl_q[`CFS_BIT_INVERT];          // [RULE7]
    end
  end

  // timer control: hold clear until triggered, or sync pulse
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      timer_hold_o <= 1'b0;
      timer_sync_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      timer_hold_o <= ctrl_q[`CFS_BIT_TRIG_SEL] && !run_q; // [RULE10] [RULE11]
      // sync pulse only for codes that may drive a timebase
      timer_sync_o <= !ctrl_q[`CFS_BIT_TRIG_SEL] && src_hit
                   && (src_kind == CFS_SRC_KIND_SYNC);     // [RULE10]
    end
  end

  // cascade pairing is a plain copy; the partner channel does the joining
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cascade_enable_o <= 1'b0;
    else if (clk_en_i)
      cascade_enable_o <= ctrl_q[`CFS_BIT_CASCADE];        // [RULE9]
  end

  // status mirrors
  // one flop of lag keeps every output straight from a register
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fault_a_status_o     <= 1'b0;
      trigger_run_status_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fault_a_status_o     <= flt_stat_q;
      trigger_run_status_o <= run_q;
    end
  end

  // read port: data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 16'h0000;
    else if (clk_en_i)
    begin
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i && reg_addr_i == ADDR_W'(`CFS_OFS_CTRL2))
      begin
        // bit 11 is never stored, so it reads as zero
        reg_rdata_o <= ctrl_q;
        reg_rdata_o[`CFS_BIT_RUN_STAT] <= run_q;
      end
      // status register holds only the fault a bit
      else if (reg_rd_i && reg_addr_i == ADDR_W'(`CFS_OFS_STATUS))
        reg_rdata_o[`CFS_BIT_FLT_STAT] <= flt_stat_q;
    end
  end

endmodule

`default_nettype wire

/* design/cfs_params.svh */
// constants for the compare fault / sync control stage
// assumes a 16-bit control register and a 5-bit source code
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// register indices on the plain register port
`define CFS_OFS_CTRL2      4'h0
`define CFS_OFS_STATUS     4'h1

// control register two field positions
`define CFS_BIT_FLT_HOLD   15
`define CFS_BIT_FLT_LEVEL  14
`define CFS_BIT_FLT_FORCE  13
`define CFS_BIT_INVERT     12
`define CFS_BIT_DLY_HI     10
`define CFS_BIT_DLY_LO     9
`define CFS_BIT_CASCADE    8
`define CFS_BIT_TRIG_SEL   7
`define CFS_BIT_RUN_STAT   6
`define CFS_BIT_TRISTATE   5
`define CFS_BIT_SRC_HI     4

// reset value and writable bits (bit 11 and bit 6 handled apart)
`define CFS_CTRL2_RESET    16'h000C
`define CFS_CTRL2_WMASK    16'hF7BF

// status register: fault a status, write one to clear
`define CFS_BIT_FLT_STAT   0

// compare mode codes
`define CFS_MODE_SS_HIGH   3'b001
`define CFS_MODE_PWM_EDGE  3'b110
`define CFS_MODE_PWM_CTR   3'b111

// source select codes
`define CFS_SRC_NONE       5'b00000
`define CFS_SRC_CMP_FIRST  5'b00001
`define CFS_SRC_CMP_LAST   5'b00101
`define CFS_SRC_CAP5       5'b01010
`define CFS_SRC_TMR_FIRST  5'b01011
`define CFS_SRC_TMR_LAST   5'b01111
`define CFS_SRC_TRG_FIRST  5'b10100
`define CFS_SRC_TRG_LAST   5'b11100
`define CFS_SRC_SELF       5'b11111

`endif

/* design/cfs_pkg.sv */
// types for the compare fault / sync control stage
// assumes cfs_params.svh supplies the numeric constants
`default_nettype none
package cfs_pkg;

  // fault response state
  typedef enum logic
  {
    CFS_FLT_IDLE,
    CFS_FLT_ACTIVE
  } cfs_flt_state_t;

  // class of a source select code
  typedef enum logic [1:0]
  {
    CFS_SRC_KIND_NONE,
    CFS_SRC_KIND_SYNC,
    CFS_SRC_KIND_TRIG
  } cfs_src_kind_t;

endpackage

`default_nettype wire

/* testbench/cfs_compare_ctrl_assertions.sv */
// checker for the compare fault / sync control stage
// assumes clk_en_i held high; bound to the design top below
`timescale 1ns/1ps
`default_nettype none
`include "cfs_params.svh"
module cfs_compare_ctrl_chk
#(
  parameter int unsigned ADDR_W = 4
)
(
  input wire logic              mclk_i,                  // clock
  input wire logic              arst_n_i,                // reset, active low
  input wire logic [ADDR_W-1:0] reg_addr_i,              // register index
  input wire logic [15:0]       reg_wdata_i,             // write data
  input wire logic              reg_wr_i,                // write strobe
  input wire logic              reg_rd_i,                // read strobe
  input wire logic [15:0]       reg_rdata_o,             // read data
  input wire logic [2:0]        compare_mode_select_i,   // core mode
  input wire logic              period_start_i,          // period start
  input wire logic              fault_src_i,             // fault pin
  input wire logic [31:0]       src_event_i,             // source pulses
  input wire logic              compare_output_pin_o,    // pin level
  input wire logic              compare_output_pin_oe_o, // pin enable
  input wire logic [1:0]        edge_delay_o,            // delay code
  input wire logic              delay_on_rise_o,         // delay rising edge
  input wire logic              timer_hold_o,            // timer held
  input wire logic              timer_sync_o,            // sync pulse
  input wire logic              trigger_run_status_o     // run status
);
  logic [15:0] c_q;
  logic        sync_ok;
  // shadow of software writes; run status bit left out since hardware owns it
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
      c_q <= `CFS_CTRL2_RESET;
    else if (reg_wr_i && reg_addr_i == `CFS_OFS_CTRL2)
      c_q <= reg_wdata_i & `CFS_CTRL2_WMASK;
  // source codes that may resync the timebase
  assign sync_ok = !c_q[7] && src_event_i[c_q[4:0]]
    && (c_q[4:0] inside {[5'd1:5'd5], [5'd11:5'd15], 5'd31});
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RDATA: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `CFS_OFS_CTRL2
    |-> (reg_rdata_o & 16'hFFBF) == $past(c_q)) else $error("control read wrong");
  AST_DLY_SS: assert property ($past(compare_mode_select_i) == 3'b001
    |-> edge_delay_o == 2'b00) else $error("delay not zero in single-shot");
  // the active copy lags mode and period pulse by one edge, the output by one more
  AST_DLY_HOLD: assert property ($past(compare_mode_select_i[2:1], 2) == 2'b11
    && !$past(period_start_i, 2) && $past(compare_mode_select_i) != 3'b001
    |-> $stable(edge_delay_o)) else $error("delay moved mid-period");
  AST_DLY_LOAD: assert property ($past(compare_mode_select_i) != 3'b001
    && ($past(compare_mode_select_i[2:1], 2) != 2'b11 || $past(period_start_i, 2))
    |-> edge_delay_o == $past(c_q[10:9], 2)) else $error("delay code wrong");
  AST_INV_RISE: assert property (delay_on_rise_o == $past(c_q[12]))
    else $error("delay edge select wrong");
  AST_OE: assert property (!$past(c_q[13])
    |-> compare_output_pin_oe_o == !$past(c_q[5])) else $error("pin enable wrong");
  AST_HOLD: assert property (timer_hold_o == ($past(c_q[7]) && !trigger_run_status_o))
    else $error("timer hold wrong");
  AST_SYNC: assert property (timer_sync_o == $past(sync_ok))
    else $error("sync pulse wrong");
  AST_FAULT: assert property ((fault_src_i && compare_mode_select_i[2:1] == 2'b11) [*5]
    |=> compare_output_pin_o == c_q[14] && (compare_output_pin_oe_o || !c_q[13]))
    else $error("fault drive wrong");
  // main scenarios reached
  cover property ($rose(trigger_run_status_o));
  cover property (timer_sync_o);
  cover property (fault_src_i && compare_output_pin_oe_o && c_q[5]);
endmodule
bind cfs_compare_ctrl cfs_compare_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .compare_mode_select_i(compare_mode_select_i),
  .period_start_i(period_start_i), .fault_src_i(fault_src_i), .src_event_i(src_event_i),
  .compare_output_pin_o(compare_output_pin_o), .compare_output_pin_oe_o(compare_output_pin_oe_o),
  .edge_delay_o(edge_delay_o), .delay_on_rise_o(delay_on_rise_o), .timer_hold_o(timer_hold_o),
  .timer_sync_o(timer_sync_o), .trigger_run_status_o(trigger_run_status_o));
`default_nettype wire

/* testbench/cfs_compare_ctrl_tb_top.sv */
// bench for the compare fault / sync control stage
// assumes the checker is bound and the partner model compiled
`timescale 1ns/1ps
`default_nettype none
`include "cfs_params.svh"
module cfs_compare_ctrl_tb_top;
  logic        mclk, arst_n, wr, rd, acl, cmp, ps, flt, ev_en;
  logic        pin, oe, rise, casc, hold, sync, fstat, run, pin_w;
  logic [3:0]  addr;
  logic [15:0] wdata, sec, cnt, rdata;
  logic [2:0]  mode;
  logic [4:0]  ev_code;
  logic [31:0] ev;
  logic [1:0]  dly;
  int          fails, compares, cycles;
  cfs_compare_ctrl DUT (.mclk_i(mclk), .arst_n_i(arst_n), .clk_en_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .compare_mode_select_i(mode), .trigger_status_auto_clear_i(acl),
    .secondary_compare_value_i(sec), .compare_timer_count_i(cnt), .cmp_level_i(cmp),
    .period_start_i(ps), .fault_src_i(flt), .src_event_i(ev), .compare_output_pin_o(pin),
    .compare_output_pin_oe_o(oe), .edge_delay_o(dly), .delay_on_rise_o(rise),
    .cascade_enable_o(casc), .timer_hold_o(hold), .timer_sync_o(sync),
    .fault_a_status_o(fstat), .trigger_run_status_o(run));
  cfs_partner u_far (.ev_en_i(ev_en), .ev_code_i(ev_code), .pin_i(pin), .oe_i(oe),
    .src_event_o(ev), .pin_wire_o(pin_w));
  // 10 MHz clock
  always #50 mclk = ~mclk;
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic fire(input logic [4:0] c);
    @(posedge mclk);
    ev_code <= c;
    ev_en <= 1'b1;
    @(posedge mclk);
    ev_en <= 1'b0;
    #1;
  endtask
  task automatic pulse();
    @(posedge mclk);
    ps <= 1'b1;
    @(posedge mclk);
    ps <= 1'b0;
    #1;
  endtask
  task automatic t_regs();
    rd_reg(4'h0, `CFS_CTRL2_RESET, "ctrl reset");
    wr_reg(4'h0, 16'hFFEB);
    rd_reg(4'h0, 16'hF7EB, "ctrl ones");
    wr_reg(4'h0, 16'h0000);
    rd_reg(4'h0, 16'h0000, "ctrl zero");
    rd_reg(4'h2, 16'h0000, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_trig();
    wr_reg(4'h0, 16'h008C);
    tick(2);
    chk("hold before", 1'b1, hold);
    fire(5'd12);
    tick(1);
    chk("run", 1'b1, run);
    chk("hold after", 1'b0, hold);
    @(posedge mclk);
    acl <= 1'b1;
    cnt <= 16'h0005;
    tick(3);
    chk("auto clear", 1'b0, run);
    @(posedge mclk);
    acl <= 1'b0;
    $display("test trigger done");
  endtask
  task automatic t_sync();
    logic [4:0] sc [9] = '{5'd0, 5'd1, 5'd5, 5'd6, 5'd10, 5'd11, 5'd15, 5'd20, 5'd31};
    logic [8:0] ex = 9'b1_0110_0110;
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(4'h0, {11'h000, sc[i]});
      fire(sc[i]);
      chk("sync", ex[i], sync);
    end
    $display("test sync done");
  endtask
  task automatic t_out();
    @(posedge mclk);
    mode <= 3'b011;
    cmp <= 1'b1;
    wr_reg(4'h0, 16'h1700);
    tick(2);
    chk("inverted pin", 1'b0, pin);
    chk("rise delay", 1'b1, rise);
    chk("delay code", 2'b11, dly);
    chk("cascade", 1'b1, casc);
    @(posedge mclk);
    mode <= 3'b001;
    tick(2);
    chk("delay single shot", 2'b00, dly);
    wr_reg(4'h0, 16'h0220);
    mode <= 3'b110;
    tick(2);
    chk("tristate", 1'b0, pin_w | oe);
    chk("delay held", 2'b11, dly);
    pulse();
    tick(1);
    chk("delay loaded", 2'b01, dly);
    $display("test output done");
  endtask
  task automatic t_fault();
    @(posedge mclk);
    mode <= 3'b111;
    cmp <= 1'b0;
    wr_reg(4'h0, 16'hE020);
    flt <= 1'b1;
    tick(6);
    chk("fault pin", 2'b11, {pin_w, oe});
    chk("fault status", 1'b1, fstat);
    @(posedge mclk);
    flt <= 1'b0;
    pulse();
    tick(4);
    chk("fault held", 1'b1, pin_w);
    wr_reg(4'h1, 16'h0001);
    tick(4);
    chk("fault left", 2'b00, {pin_w, oe});
    wr_reg(4'h0, 16'h6020);
    flt <= 1'b1;
    tick(6);
    @(posedge mclk);
    flt <= 1'b0;
    tick(4);
    chk("wait period", 1'b1, pin_w);
    pulse();
    tick(3);
    chk("period exit", 1'b0, pin_w);
    $display("test fault done");
  endtask
  // every input has a value at time zero; reset for six cycles
  initial
  begin
    {mclk, arst_n, wr, rd, acl, cmp, ps, flt, ev_en} = '0;
    {addr, wdata, mode, ev_code, sec, cnt} = '0;
    sec = 16'h0005;
    cnt = 16'h0007;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_trig();
    t_sync();
    t_out();
    t_fault();
    print_verdict();
  end
endmodule
`default_nettype wire

/* testbench/cfs_partner.sv */
// far side model: other trigger sources and the pin load
// assumes the bench names one source code to fire per pulse
`timescale 1ns/1ps
`default_nettype none
module cfs_partner (
  input  wire logic        ev_en_i,     // fire one source
  input  wire logic [4:0]  ev_code_i,   // code of the source
  input  wire logic        pin_i,       // pin level from block
  input  wire logic        oe_i,        // pin enable from block
  output logic      [31:0] src_event_o, // pulses by code
  output logic             pin_wire_o   // resolved pin
);
  // one source at a time; trigger-only codes never meant as sync
  assign src_event_o = ev_en_i ? (32'h0000_0001 << ev_code_i) : 32'h0000_0000;
  // pull-down load, so a released pin never shows a stale level
  assign pin_wire_o = oe_i ? pin_i : 1'b0;
endmodule
`default_nettype wire
